// *** hw/radio_link_csr_bank.sv ***
// Control and status register bank of the radio link core.
// Assumes a word-wide memory-mapped master on clk_sys and event pulses
// from link logic in the same clock domain.
`timescale 1ns/100ps
`default_nettype none
`include "radio_link_csr_cfg.svh"

// Function
// - Registers are reached through the memory-mapped slave port; the stored words also drive csr_words.
// - Registers are 32-bit words at byte addresses stepping by 4.
// - Writes to reserved bits or unmapped addresses change no state.
// - Decode interrupt, layer-one status/config and line-rate registers.
// - Decode protocol version and scrambler registers at 0x10-0x18.
// - Decode start-up sequence control and timer registers.
// - Decode in-band alarm and control word registers at 0x2C-0x38.
// - Decode transmit and receive buffer latency registers.
// - Decode extended latency and loop latency registers.
// - Decode bit slip and one-way calibration registers.
// - Decode loop calibration and transceiver FIFO latency registers.
// - Bit 18: SDI pending flag, read-write, cleared at reset.
// - Bit 17: RAI pending flag, read-write, cleared at reset.
// - Bit 16: remote reset pending flag, read-write, cleared at reset.
// - Bit 2: SDI interrupt enable, read-write, cleared at reset.
// - Bit 1: RAI interrupt enable, read-write, cleared at reset.
// - Bit 0: remote reset interrupt enable, read-write, cleared at reset.
module radio_link_csr_bank
   import radio_link_csr_pkg::*;
(
   input  wire logic                            clk_sys,
   input  wire logic                            rstn,
   input  wire radio_link_csr_pkg::addr_t       avs_address,
   input  wire logic                            avs_read,
   input  wire logic                            avs_write,
   input  wire radio_link_csr_pkg::word_t       avs_writedata,
   input  wire radio_link_csr_pkg::byte_en_t    avs_byteenable,
   output logic                                 avs_waitrequest,
   output radio_link_csr_pkg::word_t            avs_readdata,
   output logic                                 avs_readdatavalid,
   input  wire logic                            remote_sdi_evt,
   input  wire logic                            remote_rai_evt,
   input  wire logic                            remote_reset_evt,
   output logic                                 irq,
   output radio_link_csr_pkg::word_array_t      csr_words
);
   import radio_link_csr_pkg::*;

   state_t    q;
   state_t    d;
   word_idx_t idx;
   logic      full_word;
   logic      hit;
   logic      wr_ok;
   cause_t    evt;
   word_t     intr_word;

   function automatic logic is_mapped(input addr_t a);
      unique case (a)
         `RLC_OFF_INTR, `RLC_OFF_L1_STAT, `RLC_OFF_L1_CFG,
         `RLC_OFF_RATE_CFG, `RLC_OFF_PROTOCOL_VERSION_CTRL, `RLC_OFF_TX_SCRAM,
         `RLC_OFF_RX_SCRAM, `RLC_OFF_MGMT_CFG, `RLC_OFF_MGMT_STAT,
         `RLC_OFF_STARTUP_CTRL, `RLC_OFF_STARTUP_TMR,
         `RLC_OFF_INBAND_ALARM, `RLC_OFF_CW_INDEX, `RLC_OFF_TX_CW,
         `RLC_OFF_RX_CW, `RLC_OFF_RX_ERR, `RLC_OFF_FRAME_CNT,
         `RLC_OFF_LOOP_TEST, `RLC_OFF_TX_BUF_LAT, `RLC_OFF_RX_BUF_LAT,
         `RLC_OFF_TX_EXT_LAT, `RLC_OFF_RX_EXT_LAT, `RLC_OFF_LOOP_LAT,
         `RLC_OFF_SLIP_CTRL, `RLC_OFF_OWCAL_A, `RLC_OFF_OWCAL_B,
         `RLC_OFF_OWCAL_C, `RLC_OFF_OWCAL_D, `RLC_OFF_OWCAL_E,
         `RLC_OFF_OWCAL_STAT, `RLC_OFF_LOOP_CAL, `RLC_OFF_SD_TX_FIFO,
         `RLC_OFF_SD_RX_FIFO: is_mapped = 1'b1;
         default: is_mapped = 1'b0;
      endcase
   endfunction

   // Word index of a byte address; offsets step by one word
   function automatic word_idx_t word_of(input addr_t a);
      word_of = a[`RLC_IDX_MSB:`RLC_IDX_LSB];
   endfunction

   assign idx       = word_of(avs_address);
   // Partial-word writes are dropped rather than merged
   assign full_word = (avs_byteenable == `RLC_BE_ALL);
   assign hit       = is_mapped(avs_address);
   assign wr_ok     = avs_write && full_word && hit;
   assign evt[`RLC_CAUSE_SDI]   = remote_sdi_evt;
   assign evt[`RLC_CAUSE_RAI]   = remote_rai_evt;
   assign evt[`RLC_CAUSE_RESET] = remote_reset_evt;

   always_comb begin
      intr_word = `RLC_ZERO_WORD;
      intr_word[`RLC_PEND_MSB:`RLC_PEND_LSB] = q.pend;
      intr_word[`RLC_EN_MSB:`RLC_EN_LSB]     = q.en;
   end

   always_comb begin
      d        = q;
      d.rvalid = 1'b0;
      if (wr_ok) begin
         if (idx == word_of(`RLC_OFF_INTR)) begin
            // Reserved bits of the interrupt word are simply not stored
            d.en   = avs_writedata[`RLC_EN_MSB:`RLC_EN_LSB];
            d.pend = avs_writedata[`RLC_PEND_MSB:`RLC_PEND_LSB];
         end else begin
            d.words[idx] = avs_writedata;
         end
      end
      // An enabled event in the same cycle as a clearing write keeps its flag
      d.pend = d.pend | (evt & q.en);
      d.irq  = |d.pend;
      if (avs_read) begin
         d.rvalid = 1'b1;
         if (!hit) begin
            d.rdata = `RLC_ZERO_WORD;
         end else if (idx == word_of(`RLC_OFF_INTR)) begin
            d.rdata = intr_word;
         end else begin
            d.rdata = q.words[idx];
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // Fixed one-cycle read latency, so the slave never stalls
   assign avs_waitrequest   = 1'b0;
   assign avs_readdata      = q.rdata;
   assign avs_readdatavalid = q.rvalid;
   assign irq               = q.irq;
   assign csr_words         = q.words;

   sequence s_intr_write;
      avs_write && full_word && (avs_address == `RLC_OFF_INTR);
   endsequence

   sequence s_quiet;
      !remote_sdi_evt && !remote_rai_evt && !remote_reset_evt;
   endsequence

   property p_read_latency;
      @(posedge clk_sys) disable iff (!rstn)
      avs_read |=> avs_readdatavalid ##1 (!avs_readdatavalid || $past(avs_read));
   endproperty
   a_read_latency: assert property (p_read_latency)
      else $error("read data valid not one cycle after read");

   property p_intr_read;
      @(posedge clk_sys) disable iff (!rstn)
      (avs_read && avs_address == `RLC_OFF_INTR && !avs_write)
         |=> avs_readdata == $past(intr_word);
   endproperty
   a_intr_read: assert property (p_intr_read)
      else $error("interrupt word read back wrong");

   property p_unmapped_write;
      @(posedge clk_sys) disable iff (!rstn)
      (avs_write && !hit) |=> (csr_words == $past(csr_words))
         && (q.en == $past(q.en));
   endproperty
   a_unmapped_write: assert property (p_unmapped_write)
      else $error("write to unmapped address changed state");

   property p_partial_write;
      @(posedge clk_sys) disable iff (!rstn)
      (avs_write && !full_word) |=> (csr_words == $past(csr_words))
         && (q.en == $past(q.en));
   endproperty
   a_partial_write: assert property (p_partial_write)
      else $error("partial word write changed state");

   property p_word_store;
      @(posedge clk_sys) disable iff (!rstn)
      (wr_ok && idx != word_of(`RLC_OFF_INTR))
         |=> csr_words[$past(idx)] == $past(avs_writedata);
   endproperty
   a_word_store: assert property (p_word_store)
      else $error("mapped register did not take written word");

   property p_enable_write;
      @(posedge clk_sys) disable iff (!rstn)
      s_intr_write |=>
         q.en == $past(avs_writedata[`RLC_EN_MSB:`RLC_EN_LSB]);
   endproperty
   a_enable_write: assert property (p_enable_write)
      else $error("interrupt enables not written");

   property p_clear;
      @(posedge clk_sys) disable iff (!rstn)
      (s_intr_write and s_quiet) ##0
         (avs_writedata[`RLC_PEND_MSB:`RLC_PEND_LSB] == `RLC_CAUSE_OFF)
         |=> (q.pend == `RLC_CAUSE_OFF) && !irq;
   endproperty
   a_clear: assert property (p_clear)
      else $error("pending flags or interrupt not cleared");

   property p_irq_level;
      @(posedge clk_sys) disable iff (!rstn)
      irq == (|q.pend);
   endproperty
   a_irq_level: assert property (p_irq_level)
      else $error("interrupt level disagrees with pending flags");

   property p_masked;
      @(posedge clk_sys) disable iff (!rstn)
      (q.pend == `RLC_CAUSE_OFF && q.en == `RLC_CAUSE_OFF && !avs_write)
         |=> !irq;
   endproperty
   a_masked: assert property (p_masked)
      else $error("interrupt raised with all causes disabled");

   // Bus answers seen from the host side

   sequence s_map_read;
      avs_read && hit && (idx != word_of(`RLC_OFF_INTR));
   endsequence

   sequence s_bad_read;
      avs_read && !hit;
   endsequence

   sequence s_partial_write;
      avs_write && !full_word;
   endsequence

   sequence s_bad_write;
      avs_write && !hit;
   endsequence

   property p_no_stall;
      @(posedge clk_sys) disable iff (!rstn)
      !avs_waitrequest;
   endproperty
   a_no_stall: assert property (p_no_stall)
      else $error("slave port stalled");

   property p_idle_valid;
      @(posedge clk_sys) disable iff (!rstn)
      !avs_read |=> !avs_readdatavalid;
   endproperty
   a_idle_valid: assert property (p_idle_valid)
      else $error("read data valid without a read");

   // Read data must hold so a slow host can still pick it up
   property p_rdata_hold;
      @(posedge clk_sys) disable iff (!rstn)
      !avs_read |=> $stable(avs_readdata);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold)
      else $error("read data changed without a read");

   property p_map_read;
      @(posedge clk_sys) disable iff (!rstn)
      s_map_read |=> avs_readdata == $past(q.words[idx]);
   endproperty
   a_map_read: assert property (p_map_read)
      else $error("mapped register read back wrong");

   property p_bad_read;
      @(posedge clk_sys) disable iff (!rstn)
      s_bad_read |=> avs_readdata == `RLC_ZERO_WORD;
   endproperty
   a_bad_read: assert property (p_bad_read)
      else $error("unmapped read did not return zero");

   // Reserved interrupt bits are never stored, so they read as zero
   property p_intr_reserved;
      @(posedge clk_sys) disable iff (!rstn)
      (avs_read && avs_address == `RLC_OFF_INTR)
         |=> (avs_readdata & ~`RLC_INTR_USED) == `RLC_ZERO_WORD;
   endproperty
   a_intr_reserved: assert property (p_intr_reserved)
      else $error("reserved interrupt bits read nonzero");

   property p_pend_write;
      @(posedge clk_sys) disable iff (!rstn)
      (s_intr_write and s_quiet) |=>
         q.pend == $past(avs_writedata[`RLC_PEND_MSB:`RLC_PEND_LSB]);
   endproperty
   a_pend_write: assert property (p_pend_write)
      else $error("pending flags not written");

   property p_partial_pend;
      @(posedge clk_sys) disable iff (!rstn)
      (s_partial_write and s_quiet) |=> q.pend == $past(q.pend);
   endproperty
   a_partial_pend: assert property (p_partial_pend)
      else $error("partial write changed pending flags");

   property p_bad_pend;
      @(posedge clk_sys) disable iff (!rstn)
      (s_bad_write and s_quiet) |=> q.pend == $past(q.pend);
   endproperty
   a_bad_pend: assert property (p_bad_pend)
      else $error("unmapped write changed pending flags");

   property p_enable_hold;
      @(posedge clk_sys) disable iff (!rstn)
      !avs_write |=> $stable(q.en);
   endproperty
   a_enable_hold: assert property (p_enable_hold)
      else $error("interrupt enables changed without a write");

   property p_word_hold;
      @(posedge clk_sys) disable iff (!rstn)
      !avs_write |=> $stable(csr_words);
   endproperty
   a_word_hold: assert property (p_word_hold)
      else $error("stored word changed without a write");

   // The line may only rise after an enabled event or a host write
   property p_irq_rise;
      @(posedge clk_sys) disable iff (!rstn)
      $rose(irq) |-> ($past(|(evt & q.en)) || $past(avs_write));
   endproperty
   a_irq_rise: assert property (p_irq_rise)
      else $error("interrupt rose without a cause");

   genvar gi;
   generate
      for (gi = 0; gi < `RLC_NUM_CAUSE; gi++) begin : g_cause
         property p_pend_set;
            @(posedge clk_sys) disable iff (!rstn)
            (evt[gi] && q.en[gi]) |=> q.pend[gi] && irq;
         endproperty
         a_pend_set: assert property (p_pend_set)
            else $error("enabled event did not set its pending flag");

         property p_pend_hold;
            @(posedge clk_sys) disable iff (!rstn)
            (q.pend[gi] && !avs_write) |=> q.pend[gi];
         endproperty
         a_pend_hold: assert property (p_pend_hold)
            else $error("pending flag dropped without a write");

         property p_evt_masked;
            @(posedge clk_sys) disable iff (!rstn)
            (evt[gi] && !q.en[gi] && !q.pend[gi] && !avs_write)
               |=> !q.pend[gi];
         endproperty
         a_evt_masked: assert property (p_evt_masked)
            else $error("disabled event set its pending flag");

         property p_no_cause;
            @(posedge clk_sys) disable iff (!rstn)
            (!evt[gi] && !q.pend[gi] && !avs_write) |=> !q.pend[gi];
         endproperty
         a_no_cause: assert property (p_no_cause)
            else $error("pending flag set without an event");
      end
   endgenerate

endmodule

`default_nettype wire

// *** hw/radio_link_csr_cfg.svh ***
// Address map and field layout constants for the radio link register bank.
// Assumes byte addressing on a 32-bit word-wide slave port.
`ifndef RADIO_LINK_CSR_CFG_SVH
`define RADIO_LINK_CSR_CFG_SVH

`define RLC_AW          8
`define RLC_DW          32
`define RLC_BEW         4
`define RLC_BE_ALL      4'hF
`define RLC_ZERO_WORD   32'h00000000
`define RLC_NUM_WORDS   35
`define RLC_IDX_W       6
`define RLC_IDX_MSB     7
`define RLC_IDX_LSB     2
`define RLC_ALIGN_MSB   1
`define RLC_ALIGN_OK    2'h0

`define RLC_OFF_INTR          8'h00
`define RLC_OFF_L1_STAT       8'h04
`define RLC_OFF_L1_CFG        8'h08
`define RLC_OFF_RATE_CFG      8'h0C
`define RLC_OFF_PROTOCOL_VERSION_CTRL      8'h10
`define RLC_OFF_TX_SCRAM      8'h14
`define RLC_OFF_RX_SCRAM      8'h18
`define RLC_OFF_MGMT_CFG      8'h1C
`define RLC_OFF_MGMT_STAT     8'h20
`define RLC_OFF_STARTUP_CTRL  8'h24
`define RLC_OFF_STARTUP_TMR   8'h28
`define RLC_OFF_INBAND_ALARM  8'h2C
`define RLC_OFF_CW_INDEX      8'h30
`define RLC_OFF_TX_CW         8'h34
`define RLC_OFF_RX_CW         8'h38
`define RLC_OFF_RX_ERR        8'h3C
`define RLC_OFF_FRAME_CNT     8'h40
`define RLC_OFF_LOOP_TEST     8'h44
`define RLC_OFF_TX_BUF_LAT    8'h48
`define RLC_OFF_RX_BUF_LAT    8'h4C
`define RLC_OFF_TX_EXT_LAT    8'h50
`define RLC_OFF_RX_EXT_LAT    8'h54
`define RLC_OFF_LOOP_LAT      8'h58
`define RLC_OFF_SLIP_CTRL     8'h5C
`define RLC_OFF_OWCAL_A       8'h60
`define RLC_OFF_OWCAL_B       8'h64
`define RLC_OFF_OWCAL_C       8'h68
`define RLC_OFF_OWCAL_D       8'h6C
`define RLC_OFF_OWCAL_E       8'h70
`define RLC_OFF_OWCAL_STAT    8'h74
`define RLC_OFF_LOOP_CAL      8'h80
`define RLC_OFF_SD_TX_FIFO    8'h84
`define RLC_OFF_SD_RX_FIFO    8'h88

`define RLC_NUM_CAUSE   3
`define RLC_CAUSE_RESET 0
`define RLC_CAUSE_RAI   1
`define RLC_CAUSE_SDI   2
`define RLC_EN_LSB      0
`define RLC_EN_MSB      2
`define RLC_PEND_LSB    16
`define RLC_PEND_MSB    18
`define RLC_CAUSE_OFF   3'h0
`define RLC_INTR_USED   32'h00070007

`endif

// *** hw/radio_link_csr_pkg.sv ***
// Types shared by the radio link register bank.
// Assumes radio_link_csr_cfg.svh supplies the sizes.
`default_nettype none
`include "radio_link_csr_cfg.svh"

package radio_link_csr_pkg;

   typedef logic [`RLC_AW-1:0]        addr_t;
   typedef logic [`RLC_DW-1:0]        word_t;
   typedef logic [`RLC_BEW-1:0]       byte_en_t;
   typedef logic [`RLC_IDX_W-1:0]     word_idx_t;
   typedef logic [`RLC_NUM_CAUSE-1:0] cause_t;
   typedef logic [`RLC_NUM_WORDS-1:0][`RLC_DW-1:0] word_array_t;

   typedef struct packed {
      word_array_t words;
      cause_t      en;
      cause_t      pend;
      word_t       rdata;
      logic        rvalid;
      logic        irq;
   } state_t;

endpackage

`default_nettype wire

// *** dv/csr_host_model.sv ***
// Host processor model driving the register bank's slave port.
// Assumes the bank answers reads with readdatavalid and never stalls.
`timescale 1ns/100ps
`default_nettype none
module csr_host_model
   import radio_link_csr_pkg::*;
(
   input  wire logic                         clk_sys,
   output radio_link_csr_pkg::addr_t         avs_address,
   output logic                              avs_read,
   output logic                              avs_write,
   output radio_link_csr_pkg::word_t         avs_writedata,
   output radio_link_csr_pkg::byte_en_t      avs_byteenable,
   input  wire radio_link_csr_pkg::word_t    avs_readdata,
   input  wire logic                         avs_readdatavalid
);
   import radio_link_csr_pkg::*;

   initial begin
      avs_address = 8'h00;
      avs_read = 1'h0;
      avs_write = 1'h0;
      avs_writedata = 32'h00000000;
      avs_byteenable = 4'hF;
   end

   // Released address and data lines show the inverse so a stale value never looks held
   task automatic wr(input addr_t a, input word_t d, input byte_en_t be);
      @(posedge clk_sys);
      avs_address <= a;
      avs_writedata <= d;
      avs_byteenable <= be;
      avs_write <= 1'h1;
      @(posedge clk_sys);
      avs_write <= 1'h0;
      avs_address <= ~a;
      avs_writedata <= ~d;
   endtask

   // Reads of unmapped places come back to the caller, who ignores them
   task automatic rd(input addr_t a, output word_t d);
      d = 'x;
      @(posedge clk_sys);
      avs_address <= a;
      avs_byteenable <= 4'hF;
      avs_read <= 1'h1;
      @(posedge clk_sys);
      avs_read <= 1'h0;
      avs_address <= ~a;
      for (int n = 0; n < 4; n++) begin
         @(posedge clk_sys);
         if (avs_readdatavalid === 1'h1) begin
            d = avs_readdata;
            break;
         end
      end
   endtask
endmodule
`default_nettype wire

// *** dv/test_radio_link_csr_bank.sv ***
// Self-checking bench for the radio link register bank.
// Assumes the host model drives the bus and the bench drives events.
`timescale 1ns/100ps
`default_nettype none
module test_radio_link_csr_bank;
   import radio_link_csr_pkg::*;
   logic        clk_sys = 1'h0;
   logic        rstn = 1'h0;
   addr_t       avs_address;
   logic        avs_read;
   logic        avs_write;
   word_t       avs_writedata;
   byte_en_t    avs_byteenable;
   logic        avs_waitrequest;
   word_t       avs_readdata;
   logic        avs_readdatavalid;
   logic [2:0]  evt = 3'h0;
   logic        irq;
   word_array_t csr_words;
   int          miscompares = 0;
   int          checks = 0;
   int          cycles = 0;

   always #20 clk_sys = ~clk_sys;

   radio_link_csr_bank u_dut (.clk_sys(clk_sys), .rstn(rstn),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_waitrequest(avs_waitrequest),
      .avs_readdata(avs_readdata), .avs_readdatavalid(avs_readdatavalid),
      .remote_sdi_evt(evt[2]), .remote_rai_evt(evt[1]),
      .remote_reset_evt(evt[0]), .irq(irq), .csr_words(csr_words));

   csr_host_model u_host (.clk_sys(clk_sys), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_readdatavalid(avs_readdatavalid));

   task automatic check(input word_t got, input word_t exp);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic close_out();
      if (miscompares == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 3000) begin
         miscompares++;
         close_out();
      end
   end

   task automatic pulse(input int c);
      @(posedge clk_sys);
      evt[c] <= 1'h1;
      @(posedge clk_sys);
      evt <= 3'h0;
      @(posedge clk_sys);
   endtask

   task automatic t_reset();
      word_t d;
      u_host.rd(8'h00, d);
      check(d, 32'h00000000);
      check({31'h0, irq}, 32'h00000000);
      check({31'h0, avs_waitrequest}, 32'h00000000);
   endtask

   task automatic t_map();
      word_t d;
      for (int i = 1; i < 35; i++) begin
         if (i == 30 || i == 31)
            continue;
         u_host.wr(addr_t'(i * 4), 32'hC0DE0000 | word_t'(i), 4'hF);
         u_host.rd(addr_t'(i * 4), d);
         check(d, 32'hC0DE0000 | word_t'(i));
         check(csr_words[i], 32'hC0DE0000 | word_t'(i));
      end
   endtask

   task automatic t_intr();
      word_t d;
      for (int c = 0; c < 3; c++) begin
         u_host.wr(8'h00, word_t'(1) << c, 4'hF);
         pulse((c + 1) % 3);
         check({31'h0, irq}, 32'h0);
         pulse(c);
         check({31'h0, irq}, 32'h1);
         u_host.rd(8'h00, d);
         check(d & 32'h00070007, (32'h10001) << c);
         u_host.wr(8'h00, word_t'(1) << c, 4'hF);
         @(posedge clk_sys);
         check({31'h0, irq}, 32'h0);
      end
      u_host.wr(8'h00, 32'hFFFFFFFF, 4'hF);
      u_host.rd(8'h00, d);
      check(d & 32'h00070007, 32'h00070007);
      // Clearing one cause must keep the line up for the others
      u_host.wr(8'h00, 32'h00030000, 4'hF);
      @(posedge clk_sys);
      check({31'h0, irq}, 32'h1);
      u_host.wr(8'h00, 32'h00000000, 4'hF);
      @(posedge clk_sys);
      check({31'h0, irq}, 32'h0);
   endtask

   task automatic t_unmapped();
      word_array_t snap;
      word_t       d;
      addr_t       bad [6] = '{8'h78, 8'h7C, 8'h8C, 8'hFC, 8'h01, 8'h05};
      snap = csr_words;
      foreach (bad[k])
         u_host.wr(bad[k], 32'hFFFFFFFF, 4'hF);
      u_host.wr(8'h04, 32'h00000000, 4'h3);
      u_host.rd(8'h7C, d);
      u_host.rd(8'h00, d);
      check(d & 32'h00070007, 32'h00000000);
      for (int i = 0; i < 35; i++)
         check(csr_words[i], snap[i]);
   endtask

   initial begin
      repeat (10) @(posedge clk_sys);
      rstn <= 1'h1;
      t_reset();
      t_map();
      t_intr();
      t_unmapped();
      close_out();
   end
endmodule
`default_nettype wire
